// ===== wor_pkg.sv
// How it works
// - Timeout bits 15:8 live in a read/write byte resetting to 0x87.
// - Timeout bits 7:0 live in a read/write byte resetting to 0x6B.
// - Slow oscillator tick lasts 750 crystal clock periods.
// - Reset values give a one second timeout with a 26 MHz crystal.
// - Two-bit resolution weights a count as 1, 32, 1024 or 32768 ticks.
// - Second event follows the first by 4..48 slow ticks; code resets to 7.
// - Control bit 7 powers the oscillator down; clearing it starts calibration if bit 3 is set, else runs directly.
// - Control bit 3 enables oscillator calibration; resets to one.
// - Every resolution code is accepted and honoured.
package wor_pkg;
    localparam int unsigned ADDR_W          = 6;
    localparam logic [5:0]  OFF_TIMEOUT_HIGH = 6'h1E;
    localparam logic [5:0]  OFF_TIMEOUT_LOW  = 6'h1F;
    localparam logic [5:0]  OFF_CONTROL      = 6'h20;

    localparam logic [7:0]  RST_TIMEOUT_HIGH = 8'h87;
    localparam logic [7:0]  RST_TIMEOUT_LOW  = 8'h6B;
    localparam logic [7:0]  RST_CONTROL      = 8'hF8;

    localparam int unsigned BIT_POWER_DOWN  = 7;
    localparam int unsigned BIT_DELAY_HI    = 6;
    localparam int unsigned BIT_DELAY_LO    = 4;
    localparam int unsigned BIT_CAL_ENABLE  = 3;
    localparam int unsigned BIT_RES_HI      = 1;
    localparam int unsigned BIT_RES_LO      = 0;

    localparam int unsigned RC_DIVIDE       = 750;
    localparam int unsigned CAL_TICKS       = 16;
    localparam int unsigned SYNC_STAGES     = 3;
    localparam int unsigned NOMINAL_XTAL_HZ = 26_000_000;
    localparam int unsigned SPI_HDR_READ    = 7;
    localparam int unsigned SPI_HDR_BURST   = 6;

    typedef struct packed {
        logic        slow_osc_power_down;
        logic [2:0]  second_event_delay_select;
        logic        slow_osc_calibration_enable;
        logic [1:0]  wake_timeout_resolution;
        logic [15:0] wake_timeout_count;
    } wake_cfg_t;

    typedef struct packed {
        logic chip_select_n;
        logic serial_clk;
        logic serial_in;
    } spi_pins_t;
endpackage

// ===== rc_tick_divider.sv
`timescale 1ns/1ps
module rc_tick_divider #(
    parameter int unsigned DIVIDE = wor_pkg::RC_DIVIDE
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Control
    input  wire logic run_i,
    // Slow tick
    output logic      tick_o
);
    localparam int unsigned CNT_W = $clog2(DIVIDE);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(DIVIDE - 1);

    logic [CNT_W-1:0] count_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !run_i) begin
            count_reg <= '0;
        end else if (count_reg == LAST) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= run_i && (count_reg == LAST);
        end
    end
endmodule

// ===== wake_on_radio_timer.sv
`timescale 1ns/1ps
module wake_on_radio_timer #(
    parameter int unsigned CAL_TICKS = wor_pkg::CAL_TICKS
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Serial register port
    input  wire logic spi_csn_i,
    input  wire logic spi_sclk_i,
    input  wire logic spi_mosi_i,
    output logic      spi_miso_o,
    output logic      spi_miso_oe_o,
    // Timer events and status
    output logic      wake_timeout_count_o,
    output logic      second_event_delay_select_o,
    output logic      calibrating_o,
    output logic      osc_running_o
);
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_CAL = 2'b01,
        ST_RUN = 2'b11
    } osc_state_t;

    function automatic logic [14:0] res_last(input logic [1:0] code);
        case (code)
            2'd0:    res_last = 15'h0000;
            2'd1:    res_last = 15'h001F;
            2'd2:    res_last = 15'h03FF;
            default: res_last = 15'h7FFF;
        endcase
    endfunction

    function automatic logic [5:0] delay_ticks(input logic [2:0] code);
        case (code)
            3'd0:    delay_ticks = 6'h04;
            3'd1:    delay_ticks = 6'h06;
            3'd2:    delay_ticks = 6'h08;
            3'd3:    delay_ticks = 6'h0C;
            3'd4:    delay_ticks = 6'h10;
            3'd5:    delay_ticks = 6'h18;
            3'd6:    delay_ticks = 6'h20;
            default: delay_ticks = 6'h30;
        endcase
    endfunction

    // Pin synchronisers with agreement filter
    wor_pkg::spi_pins_t pins_raw;
    wor_pkg::spi_pins_t pins_reg;
    logic [2:0]         sync1_reg;
    logic [2:0]         sync2_reg;
    logic [2:0]         sync3_reg;

    assign pins_raw = '{chip_select_n: spi_csn_i, serial_clk: spi_sclk_i,
                        serial_in: spi_mosi_i};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    sync1_reg[g] <= (g == 2);
                    sync2_reg[g] <= (g == 2);
                    sync3_reg[g] <= (g == 2);
                    pins_reg[g]  <= (g == 2);
                end else begin
                    sync1_reg[g] <= pins_raw[g];
                    sync2_reg[g] <= sync1_reg[g];
                    sync3_reg[g] <= sync2_reg[g];
                    if (sync2_reg[g] == sync3_reg[g]) begin
                        pins_reg[g] <= sync3_reg[g];
                    end
                end
            end
        end
    endgenerate

    logic sclk_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= pins_reg.serial_clk;
        end
    end
    assign selected  = !pins_reg.chip_select_n;
    assign sclk_rise = selected && pins_reg.serial_clk && !sclk_prev_reg;
    assign sclk_fall = selected && !pins_reg.serial_clk && sclk_prev_reg;

    // Serial framing: header byte, then data bytes
    logic [2:0]         bit_cnt_reg;
    logic               in_data_reg;
    logic               is_read_reg;
    logic               burst_reg;
    logic [5:0]         addr_reg;
    logic [7:0]         shift_in_reg;
    logic [7:0]         shift_out_reg;
    logic [7:0]         rx_byte;
    logic               byte_done;
    logic               wr_strobe;
    logic [5:0]         rd_addr;
    logic [7:0]         rd_data;
    logic               rd_ctrl;

    assign rx_byte   = {shift_in_reg[6:0], pins_reg.serial_in};
    assign byte_done = sclk_rise && (bit_cnt_reg == 3'd7);
    assign wr_strobe = byte_done && in_data_reg && !is_read_reg;
    assign rd_addr   = in_data_reg ? addr_reg + 6'd1 : rx_byte[5:0];

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !selected) begin
            bit_cnt_reg  <= '0;
            in_data_reg  <= 1'b0;
            is_read_reg  <= 1'b0;
            burst_reg    <= 1'b0;
            addr_reg     <= '0;
            shift_in_reg <= '0;
        end else if (sclk_rise) begin
            bit_cnt_reg  <= bit_cnt_reg + 3'd1;
            shift_in_reg <= rx_byte;
            if (byte_done) begin
                in_data_reg <= 1'b1;
                if (!in_data_reg) begin
                    is_read_reg <= rx_byte[wor_pkg::SPI_HDR_READ];
                    burst_reg   <= rx_byte[wor_pkg::SPI_HDR_BURST];
                    addr_reg    <= rx_byte[5:0];
                end else if (burst_reg) begin
                    addr_reg <= addr_reg + 6'd1;
                end
            end
        end
    end

    // Read data
    wor_pkg::wake_cfg_t cfg_reg;
    always_comb begin
        case (rd_addr)
            wor_pkg::OFF_TIMEOUT_HIGH: rd_data = cfg_reg.wake_timeout_count[15:8];
            wor_pkg::OFF_TIMEOUT_LOW:  rd_data = cfg_reg.wake_timeout_count[7:0];
            wor_pkg::OFF_CONTROL:      rd_data = {cfg_reg.slow_osc_power_down,
                                                  cfg_reg.second_event_delay_select,
                                                  cfg_reg.slow_osc_calibration_enable,
                                                  1'b0,
                                                  cfg_reg.wake_timeout_resolution};
            default:                   rd_data = 8'h00;
        endcase
    end
    // Load on byte end when a read byte follows, clear on other byte ends, else shift on falling edge
    assign rd_ctrl = byte_done && (in_data_reg ? (is_read_reg && burst_reg)
                                               : rx_byte[wor_pkg::SPI_HDR_READ]);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !selected) begin
            shift_out_reg <= '0;
        end else if (rd_ctrl) begin
            shift_out_reg <= rd_data;
        end else if (byte_done) begin
            shift_out_reg <= '0;
        end else if (sclk_fall && bit_cnt_reg != 3'd0) begin
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            spi_miso_o    <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else begin
            spi_miso_o    <= shift_out_reg[7];
            spi_miso_oe_o <= selected;
        end
    end

    // Configuration registers
    logic [7:0] ctrl_wdata;
    assign ctrl_wdata = rx_byte;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cfg_reg <= {wor_pkg::RST_CONTROL[wor_pkg::BIT_POWER_DOWN:wor_pkg::BIT_CAL_ENABLE],
                        wor_pkg::RST_CONTROL[wor_pkg::BIT_RES_HI:wor_pkg::BIT_RES_LO],
                        wor_pkg::RST_TIMEOUT_HIGH, wor_pkg::RST_TIMEOUT_LOW};
        end else if (wr_strobe) begin
            case (addr_reg)
                wor_pkg::OFF_TIMEOUT_HIGH: cfg_reg.wake_timeout_count[15:8] <= rx_byte;
                wor_pkg::OFF_TIMEOUT_LOW:  cfg_reg.wake_timeout_count[7:0]  <= rx_byte;
                wor_pkg::OFF_CONTROL: begin
                    cfg_reg.slow_osc_power_down <= ctrl_wdata[wor_pkg::BIT_POWER_DOWN];
                    cfg_reg.second_event_delay_select <=
                        ctrl_wdata[wor_pkg::BIT_DELAY_HI:wor_pkg::BIT_DELAY_LO];
                    cfg_reg.slow_osc_calibration_enable <=
                        ctrl_wdata[wor_pkg::BIT_CAL_ENABLE];
                    cfg_reg.wake_timeout_resolution <=
                        ctrl_wdata[wor_pkg::BIT_RES_HI:wor_pkg::BIT_RES_LO];
                end
                default: ;
            endcase
        end
    end

    // Oscillator state
    osc_state_t state_reg;
    logic [4:0] cal_cnt_reg;
    logic       slow_tick;
    localparam logic [4:0] CAL_LAST = 5'(CAL_TICKS - 1);

    rc_tick_divider #(
        .DIVIDE (wor_pkg::RC_DIVIDE)
    ) rc_tick_divider_inst (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (state_reg != ST_OFF),
        .tick_o    (slow_tick)
    );

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_OFF;
        end else if (cfg_reg.slow_osc_power_down) begin
            state_reg <= ST_OFF;
        end else begin
            case (state_reg)
                ST_OFF: state_reg <= cfg_reg.slow_osc_calibration_enable ? ST_CAL : ST_RUN;
                ST_CAL: if (slow_tick && cal_cnt_reg == CAL_LAST) begin
                    state_reg <= ST_RUN;
                end
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || state_reg != ST_CAL) begin
            cal_cnt_reg <= '0;
        end else if (slow_tick) begin
            cal_cnt_reg <= cal_cnt_reg + 5'd1;
        end
    end

    // Event timing
    logic [14:0] prescale_reg;
    logic [15:0] count_reg;
    logic [5:0]  delay_reg;
    logic        scaled_tick;
    logic        running;
    logic        hit;

    assign running     = (state_reg == ST_RUN);
    assign scaled_tick = running && slow_tick
                         && (prescale_reg == res_last(cfg_reg.wake_timeout_resolution));
    assign hit         = scaled_tick && (count_reg + 16'd1 >= cfg_reg.wake_timeout_count);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !running) begin
            prescale_reg <= '0;
        end else if (slow_tick) begin
            prescale_reg <= (prescale_reg >= res_last(cfg_reg.wake_timeout_resolution))
                            ? 15'h0000 : prescale_reg + 15'd1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !running) begin
            count_reg <= '0;
        end else if (hit) begin
            count_reg <= '0;
        end else if (scaled_tick) begin
            count_reg <= count_reg + 16'd1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !running) begin
            delay_reg <= '0;
        end else if (hit) begin
            delay_reg <= delay_ticks(cfg_reg.second_event_delay_select);
        end else if (slow_tick && delay_reg != 6'd0) begin
            delay_reg <= delay_reg - 6'd1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wake_timeout_count_o      <= 1'b0;
            second_event_delay_select_o      <= 1'b0;
            calibrating_o <= 1'b0;
            osc_running_o <= 1'b0;
        end else begin
            wake_timeout_count_o      <= hit;
            second_event_delay_select_o      <= running && slow_tick && !hit && delay_reg == 6'd1;
            calibrating_o <= (state_reg == ST_CAL);
            osc_running_o <= running;
        end
    end
endmodule

// ===== wake_on_radio_timer_properties.sv
`timescale 1ns/1ps
module wake_on_radio_timer_properties #(
    parameter int unsigned CAL_TICKS = wor_pkg::CAL_TICKS
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Serial register port
    input wire logic spi_csn_i,
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe_o,
    // Timer
    input wire logic wake_timeout_count_o,
    input wire logic second_event_delay_select_o,
    input wire logic calibrating_o,
    input wire logic osc_running_o
);
    localparam int unsigned TK = wor_pkg::RC_DIVIDE;
    logic [31:0] gap_reg;
    logic [31:0] cal_reg;
    logic        seen_reg;

    // Cycles since the last first event
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || wake_timeout_count_o) begin
            gap_reg <= 32'h0000_0000;
        end else begin
            gap_reg <= gap_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !calibrating_o) begin
            cal_reg <= 32'h0000_0000;
        end else begin
            cal_reg <= cal_reg + 32'h0000_0001;
        end
    end

    // Gap is only meaningful once a first event has occurred in this run
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !osc_running_o) begin
            seen_reg <= 1'b0;
        end else if (wake_timeout_count_o) begin
            seen_reg <= 1'b1;
        end
    end

    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_quiet;
        $rose(rst_n_i) |-> !(wake_timeout_count_o || second_event_delay_select_o || calibrating_o || osc_running_o
                             || spi_miso_oe_o);
    endproperty
    property p_ev0_pulse;
        wake_timeout_count_o |=> !wake_timeout_count_o;
    endproperty
    property p_ev0_grid;
        wake_timeout_count_o && seen_reg |-> ((gap_reg + 1) % TK) == 0;
    endproperty
    property p_ev0_run;
        wake_timeout_count_o |-> osc_running_o;
    endproperty
    property p_ev1;
        second_event_delay_select_o |-> seen_reg && ((gap_reg + 1) % TK) == 0
                     && gap_reg + 1 >= 4 * TK && gap_reg + 1 <= 48 * TK;
    endproperty
    property p_ev1_run;
        second_event_delay_select_o |-> osc_running_o;
    endproperty
    property p_cal_len;
        $fell(calibrating_o) && osc_running_o |->
            cal_reg >= (CAL_TICKS - 1) * TK && cal_reg <= CAL_TICKS * TK + 2;
    endproperty
    property p_oe_rise;
        $rose(spi_miso_oe_o) |-> !spi_csn_i;
    endproperty
    property p_oe_fall;
        $fell(spi_miso_oe_o) |-> spi_csn_i;
    endproperty

    a_quiet: assert property (p_quiet)
        else $error("outputs active after reset");
    a_ev0_pulse: assert property (p_ev0_pulse)
        else $error("first event longer than one cycle");
    a_ev0_grid: assert property (p_ev0_grid)
        else $error("first event off the slow tick grid");
    a_ev0_run: assert property (p_ev0_run)
        else $error("first event while stopped");
    a_ev1: assert property (p_ev1)
        else $error("second event delay out of range");
    a_ev1_run: assert property (p_ev1_run)
        else $error("second event while stopped");
    a_cal_len: assert property (p_cal_len)
        else $error("calibration length wrong");
    a_oe_rise: assert property (p_oe_rise)
        else $error("data enable without select");
    a_oe_fall: assert property (p_oe_fall)
        else $error("data enable dropped while selected");

    c_ev0: cover property (wake_timeout_count_o && seen_reg);
    c_ev1: cover property (second_event_delay_select_o);
    c_cal: cover property ($fell(calibrating_o) && osc_running_o);
endmodule

bind wake_on_radio_timer wake_on_radio_timer_properties #(.CAL_TICKS(CAL_TICKS))
    wake_on_radio_timer_properties_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .spi_csn_i(spi_csn_i), .spi_sclk_i(spi_sclk_i), .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .wake_timeout_count_o(wake_timeout_count_o),
    .second_event_delay_select_o(second_event_delay_select_o), .calibrating_o(calibrating_o), .osc_running_o(osc_running_o));

// ===== host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model #(
    parameter int PH = 10
) (
    // Clock
    input  wire logic ref_clk_i,
    // Serial port
    input  wire logic miso_i,
    output logic      csn_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    initial begin
        csn_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    // Mode 0 frame of header and one data byte; clock idles low outside frames
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        @(posedge ref_clk_i);
        #1 csn_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (PH) @(posedge ref_clk_i);
            #1 sclk_o = 1'b0;
            mosi_o = frame[i];
            repeat (PH) @(posedge ref_clk_i);
            if (i < 8) begin
                rd[i] = miso_i;
            end
            #1 sclk_o = 1'b1;
        end
        repeat (PH) @(posedge ref_clk_i);
        #1 sclk_o = 1'b0;
        repeat (PH) @(posedge ref_clk_i);
        // Deselected data line must not keep the last bit
        #1 csn_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (PH) @(posedge ref_clk_i);
    endtask
endmodule

// ===== wake_on_radio_timer_test.sv
`timescale 1ns/1ps
module wake_on_radio_timer_test;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       csn, sclk, mosi, miso, miso_oe, ev0, ev1, cal, run;
    logic [7:0] rd;
    int         bad_count = 0;
    int         checks_done = 0;
    int         n, m, h;
    int         dly[2] = '{4, 6};

    always #10 clk = ~clk;

    wake_on_radio_timer #(.CAL_TICKS(2)) wake_on_radio_timer_inst (.ref_clk_i(clk),
        .rst_n_i(rst_n), .spi_csn_i(csn), .spi_sclk_i(sclk), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .wake_timeout_count_o(ev0), .second_event_delay_select_o(ev1),
        .calibrating_o(cal), .osc_running_o(run));
    host_spi_model #(.PH(10)) host_spi_model_inst (.ref_clk_i(clk), .miso_i(miso),
        .csn_o(csn), .sclk_o(sclk), .mosi_o(mosi));

    task automatic results;
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_n(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host_spi_model_inst.xfer({2'b00, a, d}, rd);
    endtask

    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        host_spi_model_inst.xfer({2'b10, a, 8'h00}, rd);
        check8(rd, exp);
    endtask

    // Cycles until the chosen output is seen high
    task automatic wait_sig(input int sel, input int limit, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (!hit) begin
            @(posedge clk);
            #1;
            cnt++;
            case (sel)
                0: hit = (ev0 === 1'b1);
                1: hit = (ev1 === 1'b1);
                2: hit = (cal === 1'b1);
                default: hit = (run === 1'b1);
            endcase
            if (!hit && cnt >= limit) begin
                bad_count++;
                $display("BAD %0t wait timed out", $time);
                results();
            end
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge clk);
        rdc(6'h1E, 8'h87);
        h = rd;
        rdc(6'h1F, 8'h6B);
        check_n((h * 256 + rd) * 750 / 26000, 1000);
        rdc(6'h20, 8'hF8);
        wr(6'h21, 8'h55);
        rdc(6'h21, 8'h00);
        wr(6'h1E, 8'h5A);
        wr(6'h1F, 8'hA5);
        rdc(6'h1E, 8'h5A);
        rdc(6'h1F, 8'hA5);
        for (n = 0; n < 8; n++) begin
            wr(6'h20, {1'b1, n[2:0], n[0], 1'b1, n[1:0]});
            rdc(6'h20, {1'b1, n[2:0], n[0], 1'b0, n[1:0]});
        end
        check8({7'h00, run}, 8'h00);
        wr(6'h1E, 8'h00);
        // Wake timing uses delay codes 0 and 1 only, at resolution code 0
        for (m = 0; m < 2; m++) begin
            wr(6'h20, 8'h80);
            wr(6'h1F, 8'(dly[m] + 1));
            wr(6'h20, 8'(m * 16));
            wait_sig(0, (dly[m] + 3) * 750, n);
            wait_sig(1, 60 * 750, n);
            check_n(n, dly[m] * 750);
            wait_sig(0, 60 * 750, n);
            check_n(n, 750);
            check8({7'h00, cal}, 8'h00);
        end
        wr(6'h20, 8'h80);
        wr(6'h1F, 8'h01);
        wr(6'h20, 8'h09);
        wait_sig(2, 100, n);
        wait_sig(3, 2000, n);
        check_n((n + 375) / 750, 2);
        wait_sig(0, 26000, n);
        wait_sig(0, 26000, n);
        check_n(n, 32 * 750);
        wr(6'h20, 8'hF8);
        check8({6'h00, run, cal}, 8'h00);
        results();
    end
endmodule
